//--- watchdog_timeout_and_reload_lock.sv
// Watchdog down-counter, time-out response and reload unlock logic
`timescale 1ns/10ps
`default_nettype none
module watchdog_timeout_and_reload_lock
    import watchdog_pkg::*;
(
    input  wire logic     sys_clk_i,                 // System clock, 40 MHz
    input  wire logic     resetn_i,                  // Async reset, active low
    input  wire reg_req_t reg_req_i,                 // Register write/read strobe, addr, data
    output logic [7:0]    reg_rdata_o,               // Read data, valid cycle after read
    input  wire logic     wdt_osc_i,                 // Dedicated slow oscillator pin
    input  wire logic     refresh_i,                 // Refresh instruction executed, pulse
    input  wire logic     stop_mode_i,               // Device is in stop mode
    input  wire logic     timeout_response_select_i, // 1 reset, 0 interrupt
    input  wire logic     always_on_option_i,        // Enable straight from reset
    output logic          irq_req_o,                 // Interrupt request pulse
    output logic          sys_reset_req_o,           // System reset request pulse
    output logic          stop_recovery_o,           // Stop mode recovery start pulse
    output logic          watchdog_timeout_flag_o,   // Sticky time-out flag
    output logic          stop_flag_o,               // Sticky stop flag
    output logic          enabled_o                  // Counter running
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        lock_state_t lock;
        logic [23:0] reload;
        logic [23:0] count;
        logic        enabled;
        logic        armed;
        logic        timeout_flag;
        logic        stop_flag;
        logic [7:0]  rdata;
        logic        irq;
        logic        rst_req;
        logic        recovery;
    } wdt_state_t;

    wdt_state_t q;
    wdt_state_t d;

    logic osc_tick;

    // ************************************************************
    // Oscillator tick
    // ************************************************************
    // The slow clock is sampled, not used as a clock, so the counter
    // and the registers share one domain and need no crossing logic.
    osc_tick_sync u_osc_tick_sync (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .osc_i     (wdt_osc_i),
        .tick_o    (osc_tick)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic       timeout;
        logic       status_read;
        logic       wr_unlock;
        logic       wr_upper;
        logic       wr_high;
        logic       wr_low;

        timeout     = 1'b0;
        status_read = 1'b0;
        wr_unlock   = reg_req_i.wr && (reg_req_i.addr == UNLOCK_PORT_ADDR);
        wr_upper    = reg_req_i.wr && (reg_req_i.addr == RELOAD_UPPER_ADDR);
        wr_high     = reg_req_i.wr && (reg_req_i.addr == RELOAD_HIGH_ADDR);
        wr_low      = reg_req_i.wr && (reg_req_i.addr == RELOAD_LOW_ADDR);

        d           = q;
        d.irq       = 1'b0;
        d.rst_req   = 1'b0;
        d.recovery  = 1'b0;
        d.armed     = 1'b1;

        // ********************************************************
        // Enable, refresh and count
        // ********************************************************
        if (!q.armed && always_on_option_i) begin
            // Strap sampled on the first edge after reset release
            d.enabled = 1'b1;
            d.count   = q.reload;
        end else if (!q.enabled) begin
            if (refresh_i) begin
                d.enabled = 1'b1;
                d.count   = q.reload;
            end
        end else if (refresh_i && (q.count > REFRESH_FLOOR)) begin
            d.count = q.reload;
        end else if (osc_tick) begin
            // Late refresh falls through here and the time-out goes on
            if (q.count <= COUNT_ONE) begin
                timeout = 1'b1;
                d.count = COUNT_MAX;
            end else begin
                d.count = q.count - COUNT_ONE;
            end
        end

        // ********************************************************
        // Time-out response
        // ********************************************************
        if (timeout) begin
            if (stop_mode_i) begin
                // Stop mode always wakes; irq goes out in the same cycle in interrupt mode, no reset
                d.recovery = 1'b1;
                d.irq      = ~timeout_response_select_i;
            end else if (timeout_response_select_i) begin
                d.rst_req  = 1'b1;
            end else begin
                d.irq      = 1'b1;
            end
        end

        // ********************************************************
        // Register reads
        // ********************************************************
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == UNLOCK_PORT_ADDR) begin
                d.rdata                     = BYTE_ZERO;
                d.rdata[STATUS_TIMEOUT_BIT] = q.timeout_flag;
                d.rdata[STATUS_STOP_BIT]    = q.stop_flag;
                status_read                 = 1'b1;
            end else if (reg_req_i.addr == RELOAD_UPPER_ADDR) begin
                d.rdata = q.count[23:16];
            end else if (reg_req_i.addr == RELOAD_HIGH_ADDR) begin
                d.rdata = q.count[15:8];
            end else if (reg_req_i.addr == RELOAD_LOW_ADDR) begin
                d.rdata = q.count[7:0];
            end else begin
                d.rdata = BYTE_ZERO;
            end
        end

        // ********************************************************
        // Sticky flags
        // ********************************************************
        // A time-out in the same cycle as the clearing read wins,
        // so an event is never lost to a racing status read.
        if (status_read) begin
            d.timeout_flag = 1'b0;
            d.stop_flag    = 1'b0;
        end
        if (timeout) begin
            d.timeout_flag = 1'b1;
            if (stop_mode_i) begin
                d.stop_flag = 1'b1;
            end
        end

        // ********************************************************
        // Unlock and reload sequence
        // ********************************************************
        // The unlock port holds no control bits; its writes only
        // move the lock machine.
        if (reg_req_i.wr) begin
            d.lock = LOCK_CLOSED;
            case (q.lock)
                LOCK_CLOSED: begin
                    if (wr_unlock && (reg_req_i.wdata == UNLOCK_CODE_FIRST)) begin
                        d.lock = LOCK_GOT_FIRST;
                    end
                end
                LOCK_GOT_FIRST: begin
                    if (wr_unlock && (reg_req_i.wdata == UNLOCK_CODE_SECOND)) begin
                        d.lock = LOCK_WANT_UPPER;
                    end else if (wr_unlock
                                 && (reg_req_i.wdata == UNLOCK_CODE_FIRST)) begin
                        d.lock = LOCK_GOT_FIRST;
                    end
                end
                LOCK_WANT_UPPER: begin
                    if (wr_upper) begin
                        d.reload[23:16] = reg_req_i.wdata;
                        d.lock          = LOCK_WANT_HIGH;
                    end
                end
                LOCK_WANT_HIGH: begin
                    if (wr_high) begin
                        d.reload[15:8] = reg_req_i.wdata;
                        d.lock         = LOCK_WANT_LOW;
                    end
                end
                LOCK_WANT_LOW: begin
                    if (wr_low) begin
                        d.reload[7:0] = reg_req_i.wdata;
                        d.lock        = LOCK_CLOSED;
                    end
                end
                default: begin
                    d.lock = LOCK_CLOSED;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q.lock         <= LOCK_CLOSED;
            q.reload       <= RELOAD_RESET;
            q.count        <= COUNT_RESET;
            q.enabled      <= 1'b0;
            q.armed        <= 1'b0;
            q.timeout_flag <= 1'b0;
            q.stop_flag    <= 1'b0;
            q.rdata        <= BYTE_ZERO;
            q.irq          <= 1'b0;
            q.rst_req      <= 1'b0;
            q.recovery     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata_o             = q.rdata;
    assign irq_req_o               = q.irq;
    assign sys_reset_req_o         = q.rst_req;
    assign stop_recovery_o         = q.recovery;
    assign watchdog_timeout_flag_o = q.timeout_flag;
    assign stop_flag_o             = q.stop_flag;
    assign enabled_o               = q.enabled;

endmodule
`default_nettype wire

//--- watchdog_pkg.sv
// Constants, types and register map of the watchdog time-out and reload lock block
// Notes on behaviour
// - Time-out when the down-counter reaches zero
// - Option bit picks interrupt or system reset
// - Interrupt mode: request interrupt, set time-out flag
// - After interrupt time-out load maximum, keep counting
// - Status read clears time-out flag
// - Stop plus interrupt: recovery, interrupt, both flags
// - Reset mode: force system reset, set flag
// - Stop plus reset: recovery instead, both flags
// - Unlock by first then second code byte
// - Unlock writes change no stored control bits
// - Any stray write relocks; reload writes refused
// - Load reload on first enable and refresh
// - Control address write-only; reads return status
// - Reload writes set value; reads return count
// - Reload is upper, high, low byte of 24
// - Counter runs from dedicated slow oscillator
// - Refresh ignored once count is two or less
// - Enable by refresh or always-on at reset
package watchdog_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] UNLOCK_PORT_ADDR  = 12'hff0;
    localparam logic [11:0] RELOAD_UPPER_ADDR = 12'hff1;
    localparam logic [11:0] RELOAD_HIGH_ADDR  = 12'hff2;
    localparam logic [11:0] RELOAD_LOW_ADDR   = 12'hff3;

    // ************************************************************
    // Codes, values after reset and counter limits
    // ************************************************************
    localparam logic [7:0]  UNLOCK_CODE_FIRST  = 8'h55;
    localparam logic [7:0]  UNLOCK_CODE_SECOND = 8'haa;
    localparam logic [7:0]  BYTE_ZERO          = 8'h00;
    localparam logic [23:0] RELOAD_RESET       = 24'h000400;
    localparam logic [23:0] COUNT_RESET        = 24'h000000;
    localparam logic [23:0] COUNT_MAX          = 24'hffffff;
    localparam logic [23:0] COUNT_ONE          = 24'h000001;
    localparam logic [23:0] REFRESH_FLOOR      = 24'h000002;

    // ************************************************************
    // Reset status byte layout
    // ************************************************************
    localparam int STATUS_STOP_BIT    = 6;
    localparam int STATUS_TIMEOUT_BIT = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        LOCK_CLOSED    = 3'b000,
        LOCK_GOT_FIRST = 3'b001,
        LOCK_WANT_UPPER = 3'b010,
        LOCK_WANT_HIGH = 3'b011,
        LOCK_WANT_LOW  = 3'b100
    } lock_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic        level;
        logic        tick;
    } osc_sync_state_t;

endpackage

//--- osc_tick_sync.sv
// Three-stage synchroniser and rising-edge tick for the watchdog oscillator
`timescale 1ns/10ps
`default_nettype none
module osc_tick_sync
    import watchdog_pkg::*;
(
    input  wire logic sys_clk_i,   // System clock
    input  wire logic resetn_i,    // Async reset, active low
    input  wire logic osc_i,       // Raw oscillator level
    output logic      tick_o       // One-cycle pulse per oscillator rise
);

    osc_sync_state_t q;
    osc_sync_state_t d;

    always_comb begin
        d       = q;
        d.s1    = osc_i;
        d.s2    = q.s1;
        d.s3    = q.s2;
        // Level moves only when the last two stages agree
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
        d.tick  = d.level & ~q.level;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule
`default_nettype wire

//--- watchdog_chk.sv
// Assertion checker for the watchdog time-out and reload lock block
`timescale 1ns/10ps
`default_nettype none
module watchdog_chk
    import watchdog_pkg::*;
(
    input wire logic       sys_clk_i,                 // System clock
    input wire logic       resetn_i,                  // Async reset, active low
    input wire reg_req_t   reg_req_i,                 // Register request
    input wire logic [7:0] reg_rdata_o,               // Read data
    input wire logic       stop_mode_i,               // Stop mode level
    input wire logic       timeout_response_select_i, // 1 reset, 0 interrupt
    input wire logic       irq_req_o,                 // Interrupt pulse
    input wire logic       sys_reset_req_o,           // Reset pulse
    input wire logic       stop_recovery_o,           // Recovery pulse
    input wire logic       watchdog_timeout_flag_o,   // Time-out flag
    input wire logic       stop_flag_o,               // Stop flag
    input wire logic       enabled_o                  // Counter running
);
    logic st_rd;
    logic any_pulse;
    assign st_rd = reg_req_i.rd && (reg_req_i.addr == UNLOCK_PORT_ADDR);
    assign any_pulse = irq_req_o || sys_reset_req_o || stop_recovery_o;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // ************************************************************
    // Properties
    // ************************************************************
    property p_irq_cause;
        irq_req_o |-> !$past(timeout_response_select_i) && watchdog_timeout_flag_o;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without interrupt mode");
    property p_rst_cause;
        sys_reset_req_o |-> $past(timeout_response_select_i) && !$past(stop_mode_i)
            && watchdog_timeout_flag_o && !irq_req_o;
    endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("bad reset request");
    property p_rec_cause;
        stop_recovery_o |-> $past(stop_mode_i) && stop_flag_o && watchdog_timeout_flag_o
            && !sys_reset_req_o;
    endproperty
    a_rec_cause: assert property (p_rec_cause) else $error("bad stop recovery");
    property p_pulse_short;
        any_pulse |=> !any_pulse [*2];
    endproperty
    a_pulse_short: assert property (p_pulse_short) else $error("pulse too long");
    property p_flag_set;
        $rose(watchdog_timeout_flag_o) |-> any_pulse;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set without time-out");
    property p_flag_hold;
        watchdog_timeout_flag_o && !st_rd |=> watchdog_timeout_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_flag_clr;
        st_rd |=> (!watchdog_timeout_flag_o && !stop_flag_o) || any_pulse;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_status;
        st_rd |=> reg_rdata_o == {1'b0, $past(stop_flag_o), $past(watchdog_timeout_flag_o), 5'h00};
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_rd_hold;
        !reg_req_i.rd |=> $stable(reg_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_en_hold;
        enabled_o |=> enabled_o;
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("watchdog stopped");
endmodule

bind watchdog_timeout_and_reload_lock watchdog_chk i_chk (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .stop_mode_i(stop_mode_i), .timeout_response_select_i(timeout_response_select_i),
    .irq_req_o(irq_req_o), .sys_reset_req_o(sys_reset_req_o),
    .stop_recovery_o(stop_recovery_o), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
    .stop_flag_o(stop_flag_o), .enabled_o(enabled_o));
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the watchdog time-out and reload lock block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import watchdog_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    reg_req_t   req = '0;
    logic [7:0] rdata;
    logic       osc = 1'b0;
    logic       refresh = 1'b0;
    logic       stop = 1'b0;
    logic       sel = 1'b0;
    logic       ao = 1'b0;
    logic       irq, rst, rec, tflag, sflag, en;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         n_irq = 0;
    int         n_rst = 0;
    int         n_rec = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    watchdog_timeout_and_reload_lock i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .wdt_osc_i(osc), .refresh_i(refresh),
        .stop_mode_i(stop), .timeout_response_select_i(sel), .always_on_option_i(ao),
        .irq_req_o(irq), .sys_reset_req_o(rst), .stop_recovery_o(rec),
        .watchdog_timeout_flag_o(tflag), .stop_flag_o(sflag), .enabled_o(en));

    always @(posedge sys_clk_i) begin
        if (irq === 1'b1) n_irq++;
        if (rst === 1'b1) n_rst++;
        if (rec === 1'b1) n_rec++;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        req = {2'b10, a, d};
        @(negedge sys_clk_i);
        req = '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge sys_clk_i);
        req = {2'b01, a, 8'h00};
        @(negedge sys_clk_i);
        req = '0;
        check(rdata, exp);
    endtask
    // Wide osc pulses so the three-stage sync and the response settle
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            osc = 1'b1;
            repeat (8) @(negedge sys_clk_i);
            osc = 1'b0;
            repeat (8) @(negedge sys_clk_i);
        end
    endtask
    task automatic refr();
        @(negedge sys_clk_i);
        refresh = 1'b1;
        @(negedge sys_clk_i);
        refresh = 1'b0;
    endtask
    task automatic load_reload(input logic [23:0] v, input bit stray);
        wr(UNLOCK_PORT_ADDR, UNLOCK_CODE_FIRST);
        wr(UNLOCK_PORT_ADDR, UNLOCK_CODE_SECOND);
        if (stray) wr(12'h100, 8'h00);
        wr(RELOAD_UPPER_ADDR, v[23:16]);
        wr(RELOAD_HIGH_ADDR, v[15:8]);
        wr(RELOAD_LOW_ADDR, v[7:0]);
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #400000;
        error_cnt++;
        $display("Error at %0t: run did not end", $time);
        test_done();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        resetn_i = 1'b1;
        check({7'h0, en}, 8'h00);
        rd(RELOAD_UPPER_ADDR, 8'h00);
        rd(RELOAD_LOW_ADDR, 8'h00);
        rd(12'h100, 8'h00);
        rd(UNLOCK_PORT_ADDR, 8'h00);
        $display("Test reset state done");
        load_reload(24'h123456, 1'b0);
        rd(UNLOCK_PORT_ADDR, 8'h00);
        refr();
        check({7'h0, en}, 8'h01);
        rd(RELOAD_UPPER_ADDR, 8'h12);
        rd(RELOAD_HIGH_ADDR, 8'h34);
        rd(RELOAD_LOW_ADDR, 8'h56);
        ticks(1);
        rd(RELOAD_LOW_ADDR, 8'h55);
        $display("Test unlock and reload done");
        load_reload(24'h000005, 1'b1);
        refr();
        rd(RELOAD_UPPER_ADDR, 8'h12);
        load_reload(24'h000005, 1'b0);
        refr();
        rd(RELOAD_LOW_ADDR, 8'h05);
        $display("Test relock done");
        for (int m = 0; m < 4; m++) begin
            @(negedge sys_clk_i);
            sel = m[0];
            stop = m[1];
            n_irq = 0;
            n_rst = 0;
            n_rec = 0;
            refr();
            ticks(3);
            refr();
            rd(RELOAD_LOW_ADDR, 8'h02);
            ticks(1);
            check(8'(n_irq + n_rst + n_rec), 8'h00);
            ticks(1);
            check(8'(n_irq), {7'h0, ~sel});
            check(8'(n_rst), {7'h0, sel & ~stop});
            check(8'(n_rec), {7'h0, stop});
            check({6'h00, sflag, tflag}, {6'h00, stop, 1'b1});
            rd(RELOAD_UPPER_ADDR, 8'hff);
            rd(UNLOCK_PORT_ADDR, {1'b0, stop, 1'b1, 5'h00});
            rd(UNLOCK_PORT_ADDR, 8'h00);
            $display("Test time-out mode %0d done", m);
        end
        @(negedge sys_clk_i);
        resetn_i = 1'b0;
        ao = 1'b1;
        stop = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        @(negedge sys_clk_i);
        check({7'h0, en}, 8'h01);
        rd(RELOAD_HIGH_ADDR, 8'h04);
        $display("Test always-on start done");
        test_done();
    end
endmodule
`default_nettype wire
